/* File: logic/sshl_pkg.sv */
// Package of shared constants and types for the synchronous serial handshake link.
package sshl_pkg;
  localparam int          DATA_W         = 8;
  localparam int          CNT_W          = 4;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [1:0]  CKSEL_DIV8     = 2'h0;
  localparam logic [1:0]  CKSEL_DIV4     = 2'h1;
  localparam logic [1:0]  CKSEL_DIV2     = 2'h2;
  localparam logic [1:0]  CKSEL_EXT      = 2'h3;
  localparam logic [1:0]  MODE_RESET     = 2'h3;
  localparam int          INSTR_DIV      = 4;
  localparam logic [2:0]  ADDR_MODE      = 3'h0;
  localparam logic [2:0]  ADDR_DATA      = 3'h1;
  localparam logic [2:0]  ADDR_CMD       = 3'h2;
  localparam logic [2:0]  ADDR_STATUS    = 3'h3;
  localparam logic [2:0]  ADDR_IRQ_EN    = 3'h4;
  localparam logic [2:0]  ADDR_IRQ_CLR   = 3'h5;
  localparam int          CMD_GO_BIT     = 0;
  localparam int          CMD_SKIP_BIT   = 1;
  localparam int          CMD_RDY_LO_BIT = 2;
  localparam int          CMD_RDY_HI_BIT = 3;
  localparam int          CMD_IRQ_ACK_BIT = 4;
  localparam int          ST_DONE_BIT    = 0;
  localparam int          ST_BUSY_BIT    = 1;
  localparam int          ST_SKIP_BIT    = 2;
  localparam int          ST_HS_BIT      = 3;
  localparam int          EV_DONE        = 0;
  localparam int          EV_SKIP        = 1;
  localparam int          EV_W           = 2;
  typedef enum logic [1:0] {
    SSHL_IDLE  = 2'b00,
    SSHL_LOW   = 2'b01,
    SSHL_HIGH  = 2'b11
  } sshl_state_t;
endpackage : sshl_pkg

/* File: logic/sshl_if.sv */
// Interface carrying the shift clock, data and handshake wires between the two ends.
interface sshl_if;
  logic sck;
  logic sdata_m2s;
  logic sdata_s2m;
  logic rx_ready_n_o;
  logic rx_ready_n_oe;
  logic rx_ready_n;
  assign rx_ready_n = rx_ready_n_oe ? rx_ready_n_o : 1'b1;
  modport dev (input sck, input sdata_m2s, output sdata_s2m, output rx_ready_n_o, output rx_ready_n_oe,
               input rx_ready_n);
  modport mst (output sck, output sdata_m2s, input sdata_s2m, input rx_ready_n);
endinterface : sshl_if

/* File: logic/sshl_slave.sv */
// Receiving end: serial shifter on an external shift clock with the active-low ready handshake.
//
// Implementation choices: the address map and strobed register access.
module sshl_slave (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  sshl_if.dev                                link,
  input  wire logic [2:0]                    addr,
  input  wire logic [sshl_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [sshl_pkg::DATA_W-1:0]   rdata,
  output logic                               irq
);
  // Receive shifter, its bit count and the flags that software polls.
  logic [sshl_pkg::DATA_W-1:0] shift_r;
  logic [sshl_pkg::CNT_W-1:0]  cnt_r;
  logic                        busy_r;
  logic                        xfer_done_flag_r;
  logic                        sck_d_r;
  logic                        skip_r;
  sshl_pkg::sshl_state_t       hs_st_r;
  // Event, enable and read-back words of the register port.
  logic [sshl_pkg::EV_W-1:0]   ev_st_r;
  logic [sshl_pkg::EV_W-1:0]   ev_en_r;
  logic [sshl_pkg::EV_W-1:0]   ev_set;
  logic [sshl_pkg::EV_W-1:0]   ev_clr;
  logic [sshl_pkg::DATA_W-1:0] rdata_nxt;
  // Decoded register writes.
  logic                        wr_data;
  logic                        wr_cmd;
  logic                        wr_irq_en;
  logic                        wr_irq_clr;
  // Decoded command bits, shift clock edges and the handshake level.
  logic                        go;
  logic                        skip_cmd;
  logic                        skip_take;
  logic                        irq_ack;
  logic                        rdy_lo_cmd;
  logic                        rdy_hi_cmd;
  logic                        rise;
  logic                        fall;
  logic                        done_ev;
  logic                        ready_low;

  // True when the write strobe addresses the given register.
  function automatic logic wr_hit(input logic       we,
                                  input logic [2:0] a,
                                  input logic [2:0] target);
    wr_hit = we && (a == target);
  endfunction

  // Picks one command bit out of a write word.
  function automatic logic cmd_bit(input logic [sshl_pkg::DATA_W-1:0] d,
                                   input int                          pos);
    cmd_bit = d[pos];
  endfunction

  // Widens an event word to the width of the register port.
  function automatic logic [sshl_pkg::DATA_W-1:0] ev_word(input logic [sshl_pkg::EV_W-1:0] ev);
    ev_word = {{(sshl_pkg::DATA_W - sshl_pkg::EV_W){1'b0}}, ev};
  endfunction

  // Packs handshake level, last skip result, busy and done into the status word.
  function automatic logic [sshl_pkg::DATA_W-1:0] status_word(input logic hs,
                                                             input logic skp,
                                                             input logic bsy,
                                                             input logic dn);
    status_word                        = '0;
    status_word[sshl_pkg::ST_HS_BIT]   = hs;
    status_word[sshl_pkg::ST_SKIP_BIT] = skp;
    status_word[sshl_pkg::ST_BUSY_BIT] = bsy;
    status_word[sshl_pkg::ST_DONE_BIT] = dn;
  endfunction

  assign wr_data    = wr_hit(wr, addr, sshl_pkg::ADDR_DATA);
  assign wr_cmd     = wr_hit(wr, addr, sshl_pkg::ADDR_CMD);
  assign wr_irq_en  = wr_hit(wr, addr, sshl_pkg::ADDR_IRQ_EN);
  assign wr_irq_clr = wr_hit(wr, addr, sshl_pkg::ADDR_IRQ_CLR);
  assign go         = wr_cmd && cmd_bit(wdata, sshl_pkg::CMD_GO_BIT);
  assign skip_cmd   = wr_cmd && cmd_bit(wdata, sshl_pkg::CMD_SKIP_BIT);
  assign irq_ack    = wr_cmd && cmd_bit(wdata, sshl_pkg::CMD_IRQ_ACK_BIT);
  assign rdy_lo_cmd = wr_cmd && cmd_bit(wdata, sshl_pkg::CMD_RDY_LO_BIT);
  assign rdy_hi_cmd = wr_cmd && cmd_bit(wdata, sshl_pkg::CMD_RDY_HI_BIT);
  // A skip only counts as taken when there is a finished byte to report.
  assign skip_take  = skip_cmd && xfer_done_flag_r;
  assign rise       = link.sck && !sck_d_r;
  assign fall       = !link.sck && sck_d_r;
  assign done_ev    = busy_r && rise && (cnt_r == sshl_pkg::BITS_PER_BYTE - 4'h1);

  // The edge detector starts at the idle level of the clock line, so reset makes no false edge.
  always_ff @(posedge clk) begin
    if (!nrst) sck_d_r <= 1'b1;
    else sck_d_r <= link.sck;
  end

  // The shifter follows every external rise; only the bit count is tied to the start command.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_r <= '0;
    end else if (wr_data) begin
      shift_r <= wdata;
    end else if (rise) begin
      shift_r <= {link.sdata_m2s, shift_r[sshl_pkg::DATA_W-1:1]};
    end
  end

  // The output bit moves on the falling edge, a half period before the far end samples it.
  always_ff @(posedge clk) begin
    if (!nrst) link.sdata_s2m <= 1'b1;
    else if (fall) link.sdata_s2m <= shift_r[0];
  end

  // Busy drops at the eighth rise after the start command; later edges still shift but count nothing.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
    end else if (go) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
    end else if (rise && busy_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (done_ev) busy_r <= 1'b0;
    end
  end

  // When the last rise and a clear meet in one cycle, the finished byte wins.
  always_ff @(posedge clk) begin
    if (!nrst) xfer_done_flag_r <= 1'b0;
    else if (done_ev) xfer_done_flag_r <= 1'b1;
    else if (go || skip_take || irq_ack) xfer_done_flag_r <= 1'b0;
  end

  // Remembers whether the latest skip found a finished byte.
  always_ff @(posedge clk) begin
    if (!nrst) skip_r <= 1'b0;
    else if (skip_cmd) skip_r <= xfer_done_flag_r;
  end

  // Handshake phase: idle with ready high, armed with ready low, byte in with ready still low.
  // Ready low is only honoured once the shifter is armed, so software cannot invert the order.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hs_st_r <= sshl_pkg::SSHL_IDLE;
    end else begin
      case (hs_st_r)
        sshl_pkg::SSHL_IDLE: begin
          if (rdy_lo_cmd && !rdy_hi_cmd && busy_r) hs_st_r <= sshl_pkg::SSHL_LOW;
        end
        sshl_pkg::SSHL_LOW: begin
          if (rdy_hi_cmd) hs_st_r <= sshl_pkg::SSHL_IDLE;
          else if (done_ev) hs_st_r <= sshl_pkg::SSHL_HIGH;
        end
        sshl_pkg::SSHL_HIGH: begin
          if (rdy_hi_cmd) hs_st_r <= sshl_pkg::SSHL_IDLE;
        end
        default: hs_st_r <= sshl_pkg::SSHL_IDLE;
      endcase
    end
  end
  assign ready_low          = (hs_st_r != sshl_pkg::SSHL_IDLE);
  assign link.rx_ready_n_o  = !ready_low;
  assign link.rx_ready_n_oe = 1'b1;

  // An event in the same cycle as its clear stays set.
  assign ev_set = {skip_take, done_ev};
  assign ev_clr = wr_irq_clr ? wdata[sshl_pkg::EV_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (!nrst) ev_st_r <= '0;
    else ev_st_r <= (ev_st_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk) begin
    if (!nrst) ev_en_r <= '0;
    else if (wr_irq_en) ev_en_r <= wdata[sshl_pkg::EV_W-1:0];
  end
  assign irq = |(ev_st_r & ev_en_r);

  // Read data are chosen here and registered below, so they stand only in the cycle after the strobe.
  always_comb begin
    rdata_nxt = '0;
    if (rd) begin
      case (addr)
        sshl_pkg::ADDR_DATA:    rdata_nxt = shift_r;
        sshl_pkg::ADDR_STATUS:  rdata_nxt = status_word(!ready_low, skip_r, busy_r, xfer_done_flag_r);
        sshl_pkg::ADDR_IRQ_EN:  rdata_nxt = ev_word(ev_en_r);
        sshl_pkg::ADDR_IRQ_CLR: rdata_nxt = ev_word(ev_st_r);
        default:                rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) rdata <= '0;
    else rdata <= rdata_nxt;
  end
endmodule // sshl_slave

/* File: logic/sshl_master.sv */
// Transmitting end: internal shift clock from a divider, started only on ready low.
module sshl_master (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  sshl_if.mst                                link,
  input  wire logic [2:0]                    addr,
  input  wire logic [sshl_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [sshl_pkg::DATA_W-1:0]   rdata,
  output logic                               irq
);
  logic [sshl_pkg::DATA_W-1:0] shift_r;
  logic [1:0]                  mode_r;
  logic [3:0]                  pre_r;
  logic [3:0]                  div_r;
  logic [sshl_pkg::CNT_W-1:0]  cnt_r;
  logic                        busy_r, done_r, skip_r, sck_r, out_r;
  logic [sshl_pkg::EV_W-1:0]   ev_st_r, ev_en_r;
  logic                        tick, go, skip_take, irq_ack, done_ev, wcmd;

  function automatic logic [3:0] half_period(input logic [1:0] sel);
    case (sel)
      sshl_pkg::CKSEL_DIV8: half_period = 4'h4;
      sshl_pkg::CKSEL_DIV4: half_period = 4'h2;
      default:              half_period = 4'h1;
    endcase
  endfunction

  assign wcmd      = wr && addr == sshl_pkg::ADDR_CMD;
  // Start is refused unless the receiver shows ready low.
  assign go        = wcmd && wdata[sshl_pkg::CMD_GO_BIT] && !link.rx_ready_n && !busy_r;
  assign skip_take = wcmd && wdata[sshl_pkg::CMD_SKIP_BIT] && done_r;
  assign irq_ack   = wcmd && wdata[sshl_pkg::CMD_IRQ_ACK_BIT];

  always_ff @(posedge clk) begin
    if (!nrst) pre_r <= '0;
    else pre_r <= (pre_r == 4'(sshl_pkg::INSTR_DIV - 1)) ? 4'h0 : pre_r + 4'h1;
  end
  assign tick = pre_r == 4'h0;

  always_ff @(posedge clk) begin
    if (!nrst) mode_r <= sshl_pkg::MODE_RESET;
    else if (wr && addr == sshl_pkg::ADDR_MODE) mode_r <= wdata[1:0];
  end

  always_ff @(posedge clk) begin
    if (!nrst) div_r <= '0;
    else if (go) div_r <= half_period(mode_r);
    else if (busy_r && tick) div_r <= (div_r == 4'h1) ? half_period(mode_r) : div_r - 4'h1;
  end

  // External mode on this end produces no clock; the line simply stays high.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      sck_r  <= 1'b1;
      cnt_r  <= '0;
    end else if (go && mode_r != sshl_pkg::CKSEL_EXT) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
    end else if (busy_r && tick && div_r == 4'h1) begin
      sck_r <= !sck_r;
      if (!sck_r) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == sshl_pkg::BITS_PER_BYTE - 4'h1) busy_r <= 1'b0;
      end
    end
  end
  assign done_ev  = busy_r && tick && div_r == 4'h1 && !sck_r && cnt_r == sshl_pkg::BITS_PER_BYTE - 4'h1;
  assign link.sck = sck_r;

  always_ff @(posedge clk) begin
    if (!nrst) shift_r <= '0;
    else if (wr && addr == sshl_pkg::ADDR_DATA && !busy_r) shift_r <= wdata;
    else if (busy_r && tick && div_r == 4'h1 && !sck_r)
      shift_r <= {link.sdata_s2m, shift_r[sshl_pkg::DATA_W-1:1]};
  end

  always_ff @(posedge clk) begin
    if (!nrst) out_r <= 1'b1;
    else if (busy_r && tick && div_r == 4'h1 && sck_r) out_r <= shift_r[0];
  end
  assign link.sdata_m2s = out_r;

  always_ff @(posedge clk) begin
    if (!nrst) done_r <= 1'b0;
    else if (done_ev) done_r <= 1'b1;
    else if (go || skip_take || irq_ack) done_r <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) skip_r <= 1'b0;
    else if (wcmd && wdata[sshl_pkg::CMD_SKIP_BIT]) skip_r <= done_r;
  end

  always_ff @(posedge clk) begin
    if (!nrst) ev_st_r <= '0;
    else ev_st_r <= (ev_st_r & ~((wr && addr == sshl_pkg::ADDR_IRQ_CLR) ? wdata[sshl_pkg::EV_W-1:0] : '0))
                    | {skip_take, done_ev};
  end

  always_ff @(posedge clk) begin
    if (!nrst) ev_en_r <= '0;
    else if (wr && addr == sshl_pkg::ADDR_IRQ_EN) ev_en_r <= wdata[sshl_pkg::EV_W-1:0];
  end
  assign irq = |(ev_st_r & ev_en_r);

  always_ff @(posedge clk) begin
    if (!nrst) rdata <= '0;
    else if (rd) begin
      case (addr)
        sshl_pkg::ADDR_MODE:    rdata <= {6'h0, mode_r};
        sshl_pkg::ADDR_DATA:    rdata <= shift_r;
        sshl_pkg::ADDR_STATUS:  rdata <= {4'h0, link.rx_ready_n, skip_r, busy_r, done_r};
        sshl_pkg::ADDR_IRQ_EN:  rdata <= {6'h0, ev_en_r};
        sshl_pkg::ADDR_IRQ_CLR: rdata <= {6'h0, ev_st_r};
        default:                rdata <= '0;
      endcase
    end else rdata <= '0;
  end
endmodule // sshl_master

/* File: bench/sshl_link_monitor.sv */
// Checker of the shift clock, data and handshake wires between the two ends.
module sshl_link_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdata_m2s,
  input wire logic sdata_s2m,
  input wire logic rx_ready_n_o,
  input wire logic rx_ready_n_oe,
  input wire logic rx_ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Counts shift clock rises while the receiver signals ready.
  logic [3:0] rise_cnt_r;
  always_ff @(posedge clk) begin
    if (!nrst || rx_ready_n) rise_cnt_r <= 4'h0;
    else if ($rose(sck)) rise_cnt_r <= rise_cnt_r + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ready_driven: assert property (rx_ready_n_oe)
    else $error("ready enable low");
  a_reset_idle: assert property ($rose(nrst) |-> rx_ready_n_o && sck && sdata_m2s)
    else $error("idle levels wrong after reset");
  a_held_in_byte: assert property (!sck |-> !rx_ready_n)
    else $error("clock pulse without ready");
  a_ready_after_byte: assert property ($rose(rx_ready_n) |-> rise_cnt_r == 4'h8)
    else $error("ready raised before eight bits");
  a_no_ninth_rise: assert property ($rose(sck) |-> rise_cnt_r < 4'h8)
    else $error("clock ran past the byte");
  a_low_width: assert property ($fell(sck) |-> !sck[*4])
    else $error("clock low phase too short");
  a_high_width: assert property ($rose(sck) && rise_cnt_r < 4'h7 |-> sck[*4])
    else $error("clock high phase too short");
  a_m2s_on_fall: assert property (sck && $past(sck) |-> $stable(sdata_m2s))
    else $error("master data moved while clock high");
  a_s2m_on_fall: assert property (sck && $past(sck) && $past(sck, 2) |-> $stable(sdata_s2m))
    else $error("slave data moved while clock high");
endmodule // sshl_link_monitor

/* File: bench/sync_serial_handshake_link_tb.sv */
// Testbench joining both ends of the link and driving their register ports.
module sync_serial_handshake_link_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, nrst, m_wr, m_rd, s_wr, s_rd, m_irq, s_irq;
  logic [2:0] m_addr, s_addr;
  logic [7:0] m_wdata, s_wdata, m_rdata, s_rdata, r;
  int         errors, compares, rises, lowc, lastlow;
  sshl_if link_if ();
  sshl_master u_sshl_master (.clk(clk), .nrst(nrst), .link(link_if), .addr(m_addr), .wdata(m_wdata), .wr(m_wr),
                             .rd(m_rd), .rdata(m_rdata), .irq(m_irq));
  sshl_slave u_sshl_slave (.clk(clk), .nrst(nrst), .link(link_if), .addr(s_addr), .wdata(s_wdata), .wr(s_wr),
                           .rd(s_rd), .rdata(s_rdata), .irq(s_irq));
  sshl_link_monitor u_sshl_link_monitor (.clk(clk), .nrst(nrst), .sck(link_if.sck), .sdata_m2s(link_if.sdata_m2s),
    .sdata_s2m(link_if.sdata_s2m), .rx_ready_n_o(link_if.rx_ready_n_o), .rx_ready_n_oe(link_if.rx_ready_n_oe),
    .rx_ready_n(link_if.rx_ready_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts shift clock rises and measures the latest low phase in clock cycles.
  always @(posedge clk) begin
    if (!link_if.sck) lowc++;
    else if (lowc != 0) begin
      lastlow = lowc;
      lowc = 0;
      rises++;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input bit m, input bit w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    if (m) {m_addr, m_wdata, m_wr, m_rd} <= {a, d, w, !w};
    else {s_addr, s_wdata, s_wr, s_rd} <= {a, d, w, !w};
    @(posedge clk);
    {m_wr, m_rd, s_wr, s_rd} <= 4'h0;
    #1 r = m ? m_rdata : s_rdata;
  endtask
  task automatic rc(input bit m, input logic [2:0] a, input logic [7:0] exp);
    acc(m, 1'b0, a, 8'h00);
    chk(r, exp);
  endtask
  task automatic poll(input bit m);
    r = 8'h00;
    for (int i = 0; i < 400 && r[sshl_pkg::ST_DONE_BIT] !== 1'b1; i++) acc(m, 1'b0, sshl_pkg::ADDR_STATUS, 8'h00);
    chk(r[sshl_pkg::ST_DONE_BIT], 8'h01);
  endtask
  task automatic xfer(input logic [1:0] mode, input logic [7:0] mb, input logic [7:0] sb);
    acc(1, 1, sshl_pkg::ADDR_MODE, {6'h00, mode});
    acc(1, 1, sshl_pkg::ADDR_DATA, mb);
    acc(0, 1, sshl_pkg::ADDR_DATA, sb);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_GO_BIT);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_RDY_LO_BIT);
    rises = 0;
    acc(1, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_GO_BIT);
    poll(1);
    chk(m_irq, 8'h00);
    poll(0);
    chk(s_irq, 8'h01);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_SKIP_BIT);
    rc(0, sshl_pkg::ADDR_STATUS, 8'h04);
    rc(0, sshl_pkg::ADDR_IRQ_CLR, 8'h03);
    acc(0, 1, sshl_pkg::ADDR_IRQ_CLR, 8'h03);
    chk(s_irq, 8'h00);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_RDY_HI_BIT);
    chk(rises, 8);
    chk(lastlow, sshl_pkg::INSTR_DIV * (4 >> mode));
    rc(0, sshl_pkg::ADDR_DATA, mb);
    rc(1, sshl_pkg::ADDR_DATA, sb);
    rc(0, sshl_pkg::ADDR_STATUS, 8'h0c);
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {nrst, m_wr, m_rd, s_wr, s_rd, m_addr, s_addr, m_wdata, s_wdata} = '0;
    {errors, compares, rises, lowc, lastlow} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk(link_if.rx_ready_n, 8'h01);
    chk(link_if.sck, 8'h01);
    rc(1, 3'h7, 8'h00);
    acc(1, 1, sshl_pkg::ADDR_MODE, 8'h02);
    acc(1, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_GO_BIT);
    rc(1, sshl_pkg::ADDR_STATUS, 8'h08);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_RDY_LO_BIT);
    rc(0, sshl_pkg::ADDR_STATUS, 8'h08);
    acc(0, 1, sshl_pkg::ADDR_IRQ_EN, 8'h01);
    for (int k = 0; k < 3; k++) xfer(k[1:0], 8'ha5 ^ k[7:0], 8'h3c + k[7:0]);
    xfer(2'h2, 8'h80, 8'h01);
    rc(1, sshl_pkg::ADDR_STATUS, 8'h09);
    acc(1, 1, sshl_pkg::ADDR_IRQ_EN, 8'h01);
    chk(m_irq, 8'h01);
    acc(1, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_IRQ_ACK_BIT);
    rc(1, sshl_pkg::ADDR_STATUS, 8'h08);
    rc(1, sshl_pkg::ADDR_IRQ_CLR, 8'h01);
    acc(1, 1, sshl_pkg::ADDR_IRQ_CLR, 8'h01);
    chk(m_irq, 8'h00);
    rc(1, sshl_pkg::ADDR_IRQ_EN, 8'h01);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_GO_BIT);
    acc(0, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_RDY_LO_BIT);
    acc(1, 1, sshl_pkg::ADDR_MODE, 8'h03);
    acc(1, 1, sshl_pkg::ADDR_CMD, 8'h01 << sshl_pkg::CMD_GO_BIT);
    repeat (40) @(posedge clk);
    rc(1, sshl_pkg::ADDR_STATUS, 8'h00);
    chk(link_if.sck, 8'h01);
    rc(1, sshl_pkg::ADDR_MODE, 8'h03);
    print_verdict();
  end
  initial begin
    #(100 * 20000);
    errors++;
    print_verdict();
  end
endmodule // sync_serial_handshake_link_tb
